// >>> design/pipm_chan_detect.sv
// Channel front end: pin selection, sampling and edge detection.
// Assumes pins are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pipm_chan_detect #(
   parameter int NPINS = 96
) (
   input  wire logic                                              core_clk,
   input  wire logic                                              resetn,
   input  wire logic [NPINS-1:0]                                  pinBus,
   input  wire logic [pipm_pkg::CHANNELS*pipm_pkg::SEL_W-1:0]     sysCfgPinSel,
   pipm_chan_if.src                                               chanBus
);
   logic [pipm_pkg::CHANNELS-1:0] cur_reg;
   logic [pipm_pkg::CHANNELS-1:0] prev_reg;
   logic [pipm_pkg::CHANNELS-1:0] cur_next;

   // ****************************************
   // Selection
   // ****************************************
   always_comb begin
      logic [pipm_pkg::SEL_W-1:0] sel;
      sel = '0;
      for (int c = 0; c < pipm_pkg::CHANNELS; c++) begin
         sel = sysCfgPinSel[c*pipm_pkg::SEL_W +: pipm_pkg::SEL_W];
         // Excluded or absent pins read low so a bad selection stays quiet
         if (sel == pipm_pkg::EXCLUDED_PORT2_LINE_EIGHT ||
             sel == pipm_pkg::EXCLUDED_PORT2_LINE_TWENTYTHREE ||
             int'(sel) >= NPINS) begin
            cur_next[c] = 1'b0;
         end else begin
            cur_next[c] = pinBus[sel];
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cur_reg  <= '0;
         prev_reg <= '0;
      end else begin
         cur_reg  <= cur_next;
         prev_reg <= cur_reg;
      end
   end

   assign chanBus.level = cur_reg;
   assign chanBus.rise  = cur_reg & ~prev_reg;
   assign chanBus.fall  = ~cur_reg & prev_reg;
endmodule
`default_nettype wire

// >>> design/pipm_chan_if.sv
// Interface carrying sampled channel levels and edge pulses.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface pipm_chan_if;
   logic [pipm_pkg::CHANNELS-1:0] level;
   logic [pipm_pkg::CHANNELS-1:0] rise;
   logic [pipm_pkg::CHANNELS-1:0] fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> design/pipm_pkg.sv
// Package of constants for the pin interrupt and pattern match block.
// Assumes one clock domain and a plain single-cycle register port.
package pipm_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int CHANNELS = 8;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int SEL_W    = 7;
   localparam int COND_W   = 3;
   localparam int SRC_W    = 3;

   // ****************************************
   // Pin numbering: port * 32 + line
   // ****************************************
   localparam logic [SEL_W-1:0] EXCLUDED_PORT2_LINE_EIGHT       = 7'h48;
   localparam logic [SEL_W-1:0] EXCLUDED_PORT2_LINE_TWENTYTHREE = 7'h57;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ENRISE   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ENFALL   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RISEST   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_FALLST   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_REQST    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PMCTRL   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_PMSRC    = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_PMCOND   = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_PMEND    = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_EVSTAT   = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_EVMASK   = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_PINLVL   = 8'h34;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int PMCTRL_MODE_BIT = 0;
   localparam int PMCTRL_EVNT_BIT = 1;
   localparam logic [CHANNELS-1:0]        RST_BYTE  = 8'h00;
   localparam logic [CHANNELS*SRC_W-1:0]  RST_SRC   = 24'hfac688;
   localparam logic [CHANNELS*COND_W-1:0] RST_COND  = 24'hffffff;
   localparam logic [DATA_W-1:0]          RD_ZERO   = 32'h00000000;

   // ****************************************
   // Slice conditions
   // ****************************************
   localparam logic [COND_W-1:0] COND_ALWAYS = 3'h0;
   localparam logic [COND_W-1:0] COND_RISE   = 3'h1;
   localparam logic [COND_W-1:0] COND_FALL   = 3'h2;
   localparam logic [COND_W-1:0] COND_EITHER = 3'h3;
   localparam logic [COND_W-1:0] COND_HIGH   = 3'h4;
   localparam logic [COND_W-1:0] COND_LOW    = 3'h5;
   localparam logic [COND_W-1:0] COND_EVENT  = 3'h6;
   localparam logic [COND_W-1:0] COND_NEVER  = 3'h7;

endpackage

// >>> design/pipm_pm_slice.sv
// One pattern-match slice: sticky edge memory and condition test.
// Assumes level, rise and fall come from the same channel sample.
`timescale 1ns/1ps
`default_nettype none
module pipm_pm_slice (
   input  wire logic                         core_clk,
   input  wire logic                         resetn,
   input  wire logic                         level,
   input  wire logic                         rise,
   input  wire logic                         fall,
   input  wire logic [pipm_pkg::COND_W-1:0]  cond,
   input  wire logic                         clearSticky,
   output logic                              sliceTrue
);
   logic riseSeen_reg;
   logic fallSeen_reg;

   // Set wins over a clear arriving in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         riseSeen_reg <= 1'b0;
         fallSeen_reg <= 1'b0;
      end else begin
         riseSeen_reg <= rise | (riseSeen_reg & ~clearSticky);
         fallSeen_reg <= fall | (fallSeen_reg & ~clearSticky);
      end
   end

   always_comb begin
      case (cond)
         pipm_pkg::COND_ALWAYS: sliceTrue = 1'b1;
         pipm_pkg::COND_RISE:   sliceTrue = riseSeen_reg;
         pipm_pkg::COND_FALL:   sliceTrue = fallSeen_reg;
         pipm_pkg::COND_EITHER: sliceTrue = riseSeen_reg | fallSeen_reg;
         pipm_pkg::COND_HIGH:   sliceTrue = level;
         pipm_pkg::COND_LOW:    sliceTrue = ~level;
         pipm_pkg::COND_EVENT:  sliceTrue = rise | fall;
         default:               sliceTrue = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// >>> design/pipm_top.sv
// Top of the pin interrupt and pattern match engine.
// Assumes synchronous pins, a pin selection from the system config block
// and a single-cycle register port with read data one cycle after the strobe.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pipm_top #(
   parameter int NPINS = 96
) (
   input  wire logic                                           core_clk,
   input  wire logic                                           resetn,
   input  wire logic [NPINS-1:0]                               pinBus,
   input  wire logic [pipm_pkg::CHANNELS*pipm_pkg::SEL_W-1:0]  sysCfgPinSel,
   input  wire logic [pipm_pkg::ADDR_W-1:0]                    regAddr,
   input  wire logic [pipm_pkg::DATA_W-1:0]                    regWrData,
   input  wire logic                                           regWr,
   input  wire logic                                           regRd,
   output logic      [pipm_pkg::DATA_W-1:0]                    regRdData,
   output logic      [pipm_pkg::CHANNELS-1:0]                  irqLine,
   output logic                                                irqOut,
   output logic                                                cpuReceiveEvent,
   output logic                                                wakeReq
);
   localparam int CH = pipm_pkg::CHANNELS;

   pipm_chan_if chanBus ();

   logic [CH-1:0]                   mode_reg;
   logic [CH-1:0]                   enRise_reg;
   logic [CH-1:0]                   enFall_reg;
   logic [CH-1:0]                   riseSt_reg;
   logic [CH-1:0]                   fallSt_reg;
   logic                            pmMode_reg;
   logic                            evEnab_reg;
   logic [CH*pipm_pkg::SRC_W-1:0]   pmSrc_reg;
   logic [CH*pipm_pkg::COND_W-1:0]  pmCond_reg;
   logic [CH-1:0]                   pmEnd_reg;
   logic [CH-1:0]                   evStat_reg;
   logic [CH-1:0]                   evMask_reg;
   logic [CH-1:0]                   prevReq_reg;
   logic [CH-1:0]                   irqLine_reg;
   logic                            irqOut_reg;
   logic                            cpuEv_reg;
   logic                            wake_reg;
   logic [pipm_pkg::DATA_W-1:0]     rdData_reg;
   logic [pipm_pkg::DATA_W-1:0]     rdData_next;

   logic [CH-1:0] wrHit;
   logic          wrMode;
   logic          wrEnRise;
   logic          wrEnFall;
   logic          wrRiseSt;
   logic          wrFallSt;
   logic          wrPmCtrl;
   logic          wrPmSrc;
   logic          wrPmCond;
   logic          wrPmEnd;
   logic          wrEvStat;
   logic          wrEvMask;
   logic          pmConfigWr;
   logic [CH-1:0] wByte;
   logic [CH-1:0] sliceTrue;
   logic [CH-1:0] termAcc;
   logic [CH-1:0] termEnd;
   logic [CH-1:0] termMatch;
   logic [CH-1:0] pinReq;
   logic [CH-1:0] chanReq;

   // ****************************************
   // Channel front end
   // ****************************************
   pipm_chan_detect #(
      .NPINS (NPINS)
   ) u_detect (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .pinBus       (pinBus),
      .sysCfgPinSel (sysCfgPinSel),
      .chanBus      (chanBus.src)
   );

   // ****************************************
   // Write decode
   // ****************************************
   assign wByte      = regWrData[CH-1:0];
   assign wrMode     = regWr && regAddr == pipm_pkg::OFS_MODE;
   assign wrEnRise   = regWr && regAddr == pipm_pkg::OFS_ENRISE;
   assign wrEnFall   = regWr && regAddr == pipm_pkg::OFS_ENFALL;
   assign wrRiseSt   = regWr && regAddr == pipm_pkg::OFS_RISEST;
   assign wrFallSt   = regWr && regAddr == pipm_pkg::OFS_FALLST;
   assign wrPmCtrl   = regWr && regAddr == pipm_pkg::OFS_PMCTRL;
   assign wrPmSrc    = regWr && regAddr == pipm_pkg::OFS_PMSRC;
   assign wrPmCond   = regWr && regAddr == pipm_pkg::OFS_PMCOND;
   assign wrPmEnd    = regWr && regAddr == pipm_pkg::OFS_PMEND;
   assign wrEvStat   = regWr && regAddr == pipm_pkg::OFS_EVSTAT;
   assign wrEvMask   = regWr && regAddr == pipm_pkg::OFS_EVMASK;
   // Any change of the pattern setup forgets old transitions
   assign pmConfigWr = wrPmCtrl | wrPmSrc | wrPmCond | wrPmEnd;
   assign wrHit      = {CH{1'b0}};

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_reg   <= pipm_pkg::RST_BYTE;
         enRise_reg <= pipm_pkg::RST_BYTE;
         enFall_reg <= pipm_pkg::RST_BYTE;
         evMask_reg <= pipm_pkg::RST_BYTE;
      end else begin
         if (wrMode) begin
            mode_reg <= wByte;
         end
         if (wrEnRise) begin
            enRise_reg <= wByte;
         end
         if (wrEnFall) begin
            enFall_reg <= wByte;
         end
         if (wrEvMask) begin
            evMask_reg <= wByte;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pmMode_reg <= 1'b0;
         evEnab_reg <= 1'b0;
         pmSrc_reg  <= pipm_pkg::RST_SRC;
         pmCond_reg <= pipm_pkg::RST_COND;
         pmEnd_reg  <= pipm_pkg::RST_BYTE;
      end else begin
         if (wrPmCtrl) begin
            pmMode_reg <= regWrData[pipm_pkg::PMCTRL_MODE_BIT];
            evEnab_reg <= regWrData[pipm_pkg::PMCTRL_EVNT_BIT];
         end
         if (wrPmSrc) begin
            pmSrc_reg <= regWrData[CH*pipm_pkg::SRC_W-1:0];
         end
         if (wrPmCond) begin
            pmCond_reg <= regWrData[CH*pipm_pkg::COND_W-1:0];
         end
         if (wrPmEnd) begin
            pmEnd_reg <= wByte;
         end
      end
   end

   // ****************************************
   // Pin interrupt mode
   // ****************************************
   // Edge pending bits: a new edge wins over a one written the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         riseSt_reg <= pipm_pkg::RST_BYTE;
         fallSt_reg <= pipm_pkg::RST_BYTE;
      end else begin
         riseSt_reg <= (chanBus.rise & enRise_reg & ~mode_reg) |
                       (riseSt_reg & ~(wrRiseSt ? wByte : wrHit));
         fallSt_reg <= (chanBus.fall & enFall_reg & ~mode_reg) |
                       (fallSt_reg & ~(wrFallSt ? wByte : wrHit));
      end
   end

   always_comb begin
      for (int c = 0; c < CH; c++) begin
         if (mode_reg[c]) begin
            // Level channel: enable in rise bit, active-high in fall bit
            pinReq[c] = enRise_reg[c] &
                        (chanBus.level[c] == enFall_reg[c]);
         end else begin
            pinReq[c] = riseSt_reg[c] | fallSt_reg[c];
         end
      end
   end

   // ****************************************
   // Pattern match engine
   // ****************************************
   for (genvar s = 0; s < CH; s++) begin : g_slice
      logic [pipm_pkg::SRC_W-1:0] src;
      assign src = pmSrc_reg[s*pipm_pkg::SRC_W +: pipm_pkg::SRC_W];
      pipm_pm_slice u_slice (
         .core_clk    (core_clk),
         .resetn      (resetn),
         .level       (chanBus.level[src]),
         .rise        (chanBus.rise[src]),
         .fall        (chanBus.fall[src]),
         .cond        (pmCond_reg[s*pipm_pkg::COND_W +: pipm_pkg::COND_W]),
         .clearSticky (pmConfigWr),
         .sliceTrue   (sliceTrue[s])
      );
   end

   // The last slice always closes a term, so no slice is left dangling
   assign termEnd = {1'b1, pmEnd_reg[CH-2:0]};

   always_comb begin
      termAcc[0] = sliceTrue[0];
      for (int s = 1; s < CH; s++) begin
         termAcc[s] = sliceTrue[s] & (termEnd[s-1] | termAcc[s-1]);
      end
   end

   assign termMatch = termAcc & termEnd & {CH{pmMode_reg}};

   assign chanReq = pmMode_reg ? termMatch : pinReq;

   // ****************************************
   // Outputs and event status
   // ****************************************
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqLine_reg <= pipm_pkg::RST_BYTE;
         prevReq_reg <= pipm_pkg::RST_BYTE;
         cpuEv_reg   <= 1'b0;
         wake_reg    <= 1'b0;
      end else begin
         irqLine_reg <= chanReq;
         prevReq_reg <= chanReq;
         // Only fresh matches pulse, so a held match does not flood the core
         cpuEv_reg   <= evEnab_reg & pmMode_reg &
                        (|(termMatch & ~prevReq_reg));
         // Clocked here; a sleeping core keeps this clock for the wake path
         wake_reg    <= ~pmMode_reg & (|pinReq);
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         evStat_reg <= pipm_pkg::RST_BYTE;
         irqOut_reg <= 1'b0;
      end else begin
         evStat_reg <= (chanReq & ~prevReq_reg) |
                       (evStat_reg & ~(wrEvStat ? wByte : wrHit));
         irqOut_reg <= |(evStat_reg & evMask_reg);
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_comb begin
      rdData_next = pipm_pkg::RD_ZERO;
      case (regAddr)
         pipm_pkg::OFS_MODE:   rdData_next[CH-1:0] = mode_reg;
         pipm_pkg::OFS_ENRISE: rdData_next[CH-1:0] = enRise_reg;
         pipm_pkg::OFS_ENFALL: rdData_next[CH-1:0] = enFall_reg;
         pipm_pkg::OFS_RISEST: rdData_next[CH-1:0] = riseSt_reg;
         pipm_pkg::OFS_FALLST: rdData_next[CH-1:0] = fallSt_reg;
         pipm_pkg::OFS_REQST:  rdData_next[CH-1:0] = chanReq;
         pipm_pkg::OFS_PMCTRL: begin
            rdData_next[pipm_pkg::PMCTRL_MODE_BIT] = pmMode_reg;
            rdData_next[pipm_pkg::PMCTRL_EVNT_BIT] = evEnab_reg;
         end
         pipm_pkg::OFS_PMSRC:  rdData_next[CH*pipm_pkg::SRC_W-1:0] = pmSrc_reg;
         pipm_pkg::OFS_PMCOND: rdData_next[CH*pipm_pkg::COND_W-1:0] = pmCond_reg;
         pipm_pkg::OFS_PMEND:  rdData_next[CH-1:0] = pmEnd_reg;
         pipm_pkg::OFS_EVSTAT: rdData_next[CH-1:0] = evStat_reg;
         pipm_pkg::OFS_EVMASK: rdData_next[CH-1:0] = evMask_reg;
         pipm_pkg::OFS_PINLVL: rdData_next[CH-1:0] = chanBus.level;
         default:              rdData_next = pipm_pkg::RD_ZERO;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdData_reg <= pipm_pkg::RD_ZERO;
      end else begin
         rdData_reg <= regRd ? rdData_next : pipm_pkg::RD_ZERO;
      end
   end

   assign regRdData       = rdData_reg;
   assign irqLine         = irqLine_reg;
   assign irqOut          = irqOut_reg;
   assign cpuReceiveEvent = cpuEv_reg;
   assign wakeReq         = wake_reg;
endmodule
`default_nettype wire

// >>> sim/pipm_pin_model.sv
// Far side: the pads behind the pin bus and the event input of the processor.
// Assumes channel levels from the bench and the block's own pin selection.
`timescale 1ns/1ps
`default_nettype none
module pipm_pin_model #(
   parameter int NPINS = 96
) (
   input  wire logic             core_clk,
   input  wire logic [7:0]       chanLvl,
   input  wire logic [55:0]      pinSel,
   input  wire logic             cpuReceiveEvent,
   output var  logic [NPINS-1:0] pinBus,
   output var  int               evCount
);
   // Unselected pads rest at mixed levels so a wrong selection shows
   initial begin
      pinBus = {(NPINS/2){2'b10}};
      evCount = 0;
   end
   always @(posedge core_clk) begin
      for (int c = 0; c < 8; c++) begin
         pinBus[pinSel[7*c +: 7]] <= chanLvl[c];
      end
      if (cpuReceiveEvent === 1'b1) begin
         evCount <= evCount + 1;
      end
   end
endmodule
`default_nettype wire

// >>> sim/pipm_top_properties.sv
// Checker of the pin interrupt block, watching the top ports only.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pipm_chk #(
   parameter int NPINS = 96
) (
   input wire logic             core_clk,
   input wire logic             resetn,
   input wire logic [NPINS-1:0] pinBus,
   input wire logic [55:0]      sysCfgPinSel,
   input wire logic [7:0]       regAddr,
   input wire logic [31:0]      regWrData,
   input wire logic             regWr,
   input wire logic             regRd,
   input wire logic [31:0]      regRdData,
   input wire logic [7:0]       irqLine,
   input wire logic             irqOut,
   input wire logic             cpuReceiveEvent,
   input wire logic             wakeReq
);
   // ********
   // Helpers
   // ********
   logic [7:0]      prevLine;
   logic [3:0]      quietCnt;
   wire logic [7:0] lineRise = irqLine & ~prevLine;
   wire logic       maskWr = regWr && regAddr == pipm_pkg::OFS_EVMASK;
   wire logic       clrWr = maskWr || (regWr && regAddr == pipm_pkg::OFS_EVSTAT);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Outputs may still move up to five cycles after any pin or register change
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prevLine <= 8'h00;
         quietCnt <= 4'h0;
      end else begin
         prevLine <= irqLine;
         if ($changed(pinBus) || $changed(sysCfgPinSel) || regWr) begin
            quietCnt <= 4'h0;
         end else if (quietCnt != 4'hf) begin
            quietCnt <= quietCnt + 4'h1;
         end
      end
   end
   // ********
   // Properties
   // ********
   rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
      else $error("read data outside a read cycle");
   rd_unmapped_a: assert property ($past(regRd) && $past(regAddr) == 8'hfc |-> regRdData == 32'h0)
      else $error("unmapped read not zero");
   out_quiet_a: assert property (quietCnt >= 4'h6 |-> $stable({irqLine, irqOut, wakeReq}))
      else $error("request changed without cause");
   irq_rise_a: assert property ($rose(irqOut) |-> $past(lineRise) != 8'h00 || $past(maskWr, 2))
      else $error("interrupt rose without cause");
   irq_fall_a: assert property ($fell(irqOut) |-> $past(clrWr, 2))
      else $error("interrupt fell without clear");
   wake_line_a: assert property (wakeReq |-> irqLine != 8'h00)
      else $error("wake without request");
   event_pulse_a: assert property (cpuReceiveEvent |=> !cpuReceiveEvent)
      else $error("receive event longer than a cycle");
   event_cause_a: assert property (cpuReceiveEvent |-> lineRise != 8'h00)
      else $error("receive event without new term");
   event_nowake_a: assert property (cpuReceiveEvent |-> !wakeReq)
      else $error("pattern match raised wake");
   pend_c: cover property ($rose(irqOut));
   clear_c: cover property ($fell(irqOut));
   event_c: cover property (cpuReceiveEvent);
endmodule
bind pipm_top pipm_chk #(.NPINS(NPINS)) chk (
   .core_clk(core_clk), .resetn(resetn), .pinBus(pinBus), .sysCfgPinSel(sysCfgPinSel),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .irqLine(irqLine), .irqOut(irqOut),
   .cpuReceiveEvent(cpuReceiveEvent), .wakeReq(wakeReq)
);
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the pin interrupt block with a pad model.
// Assumes package, interface, design, checker and pad model compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int NPINS = 96;
   logic core_clk, resetn, regWr, regRd, irqOut, cpuReceiveEvent, wakeReq;
   logic [7:0] regAddr, chanLvl, irqLine, evs, msk, en, pol, v;
   logic [31:0] regWrData, regRdData;
   logic [55:0] sel, selKeep;
   logic [NPINS-1:0] pinBus;
   int evCount, err_count, total_checks, seed, k;
   pipm_top #(.NPINS(NPINS)) uut (
      .core_clk(core_clk), .resetn(resetn), .pinBus(pinBus), .sysCfgPinSel(sel),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .irqLine(irqLine), .irqOut(irqOut),
      .cpuReceiveEvent(cpuReceiveEvent), .wakeReq(wakeReq));
   pipm_pin_model #(.NPINS(NPINS)) pads (
      .core_clk(core_clk), .chanLvl(chanLvl), .pinSel(sel),
      .cpuReceiveEvent(cpuReceiveEvent), .pinBus(pinBus), .evCount(evCount));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ********
   // Tasks
   // ********
   task automatic note(input bit bad, input string what);
      total_checks++;
      if (bad) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      note(regRdData !== e, $sformatf("reg %h read %h want %h", a, regRdData, e));
   endtask
   task automatic chkLine(input logic [7:0] e);
      note(irqLine !== e, $sformatf("lines %h want %h", irqLine, e));
   endtask
   task automatic chkBit(input logic g, input logic e, input string what);
      note(g !== e, what);
   endtask
   task automatic setPins(input logic [7:0] p);
      @(posedge core_clk);
      chanLvl <= p;
   endtask
   // Waits out the pad, sample, pending and output stages
   task automatic settle(input logic [7:0] e, input bit pm);
      repeat (6) @(posedge core_clk);
      #1;
      evs = evs | e;
      chkLine(e);
      chkBit(wakeReq, !pm && e != 8'h00, "wake wrong");
      chkBit(irqOut, (evs & msk) != 8'h00, "interrupt wrong");
   endtask
   task automatic print_verdict;
      if (err_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
   end
   // ********
   // Sequence
   // ********
   initial begin
      {resetn, regWr, regRd, regAddr, regWrData, chanLvl} = '0;
      {err_count, total_checks, evs, msk} = '0;
      seed = 57;
      for (int c = 0; c < 8; c++) begin
         k = c * 12 + ($unsigned($random(seed)) % 12);
         if (k == 72 || k == 87) k++;
         sel[7*c +: 7] = k[6:0];
      end
      selKeep = sel;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      chkReg(pipm_pkg::OFS_MODE, 32'h0);
      chkReg(pipm_pkg::OFS_PMSRC, {8'h00, pipm_pkg::RST_SRC});
      chkReg(pipm_pkg::OFS_PMCOND, {8'h00, pipm_pkg::RST_COND});
      wr(8'hfc, 32'hffffffff);
      chkReg(8'hfc, 32'h0);
      wr(pipm_pkg::OFS_REQST, 32'hff);
      chkReg(pipm_pkg::OFS_REQST, 32'h0);
      en = 8'($random(seed));
      pol = 8'($random(seed));
      msk = 8'hff;
      wr(pipm_pkg::OFS_ENRISE, {24'h0, en});
      chkReg(pipm_pkg::OFS_ENRISE, {24'h0, en});
      wr(pipm_pkg::OFS_ENFALL, {24'h0, pol});
      wr(pipm_pkg::OFS_EVMASK, 32'hff);
      setPins(8'hff);
      settle(en, 0);
      setPins(8'h00);
      settle(en | pol, 0);
      chkReg(pipm_pkg::OFS_RISEST, {24'h0, en});
      chkReg(pipm_pkg::OFS_FALLST, {24'h0, pol});
      wr(pipm_pkg::OFS_RISEST, 32'hff);
      settle(pol, 0);
      wr(pipm_pkg::OFS_FALLST, 32'hff);
      wr(pipm_pkg::OFS_EVMASK, 32'h0);
      msk = 8'h00;
      settle(8'h00, 0);
      chkReg(pipm_pkg::OFS_EVSTAT, {24'h0, en | pol});
      wr(pipm_pkg::OFS_EVMASK, 32'hff);
      msk = 8'hff;
      settle(8'h00, 0);
      wr(pipm_pkg::OFS_EVSTAT, 32'hff);
      evs = 8'h00;
      settle(8'h00, 0);
      wr(pipm_pkg::OFS_EVMASK, 32'h0);
      msk = 8'h00;
      en = 8'($random(seed));
      pol = 8'($random(seed));
      wr(pipm_pkg::OFS_MODE, 32'hff);
      wr(pipm_pkg::OFS_ENRISE, {24'h0, en});
      wr(pipm_pkg::OFS_ENFALL, {24'h0, pol});
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         setPins(v);
         settle(en & ~(v ^ pol), 0);
         chkReg(pipm_pkg::OFS_REQST, {24'h0, en & ~(v ^ pol)});
      end
      wr(pipm_pkg::OFS_ENRISE, 32'hff);
      wr(pipm_pkg::OFS_ENFALL, 32'hff);
      @(posedge core_clk);
      sel[42 +: 14] <= {pipm_pkg::EXCLUDED_PORT2_LINE_TWENTYTHREE,
                        pipm_pkg::EXCLUDED_PORT2_LINE_EIGHT};
      setPins(8'hff);
      settle(8'h3f, 0);
      chkReg(pipm_pkg::OFS_PINLVL, 32'h3f);
      sel <= selKeep;
      wr(pipm_pkg::OFS_MODE, 32'h0);
      wr(pipm_pkg::OFS_ENRISE, 32'h0);
      wr(pipm_pkg::OFS_ENFALL, 32'h0);
      wr(pipm_pkg::OFS_RISEST, 32'hff);
      wr(pipm_pkg::OFS_FALLST, 32'hff);
      settle(8'h00, 0);
      wr(pipm_pkg::OFS_PMEND, 32'hff);
      wr(pipm_pkg::OFS_PMCTRL, 32'h3);
      chkReg(pipm_pkg::OFS_PMCTRL, 32'h3);
      for (int c = 0; c < 8; c++) begin
         setPins(8'h00);
         repeat (4) @(posedge core_clk);
         wr(pipm_pkg::OFS_PMCOND, {8'h00, {8{c[2:0]}}});
         settle({8{c == 0 || c == 5}}, 1);
         setPins(8'hff);
         settle({8{c == 0 || c == 1 || c == 3 || c == 4}}, 1);
      end
      chkBit(evCount != 0, 1'b1, "no receive event");
      wr(pipm_pkg::OFS_PMEND, 32'h80);
      wr(pipm_pkg::OFS_PMCOND, {8'h00, {8{pipm_pkg::COND_HIGH}}});
      settle(8'h80, 1);
      setPins(8'h7f);
      wr(pipm_pkg::OFS_PMEND, 32'h88);
      settle(8'h08, 1);
      wr(pipm_pkg::OFS_PMCTRL, 32'h1);
      k = evCount;
      setPins(8'h00);
      wr(pipm_pkg::OFS_PMEND, 32'hff);
      wr(pipm_pkg::OFS_PMCOND, {8'h00, {8{pipm_pkg::COND_RISE}}});
      settle(8'h00, 1);
      setPins(8'hff);
      settle(8'hff, 1);
      chkBit(evCount == k, 1'b1, "receive event while off");
      print_verdict();
   end
endmodule
`default_nettype wire
